// File: hdl/ascr_defs.svh
`ifndef ASCR_DEFS_SVH
`define ASCR_DEFS_SVH

// ----------------------------------------
// register indices, byte address is index * 4
// ----------------------------------------
`define ASCR_IDX_STATUS 8'h01
`define ASCR_IDX_SETUP 8'h02
`define ASCR_IDX_SPAN12 8'h03
`define ASCR_IDX_SPAN34 8'h04
`define ASCR_IDX_IRQ_STAT 8'h08
`define ASCR_IDX_IRQ_MASK 8'h09

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define ASCR_RST_STATUS 8'h00
`define ASCR_RST_SETUP 8'h08
`define ASCR_RST_SPAN 8'h33
`define ASCR_SETUP_WMASK 8'h7B
`define ASCR_RST_IRQ 3'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define ASCR_ST_RESET_BIT 7
`define ASCR_ST_FAULT_BIT 6
`define ASCR_SU_HEADER_BIT 6
`define ASCR_SU_EXTCLK_BIT 5
`define ASCR_SU_LANES_HI 4
`define ASCR_SU_LANES_LO 3
`define ASCR_SU_POWER_HI 1
`define ASCR_SU_POWER_LO 0

// ----------------------------------------
// interrupt event bits
// ----------------------------------------
`define ASCR_EV_RESET 0
`define ASCR_EV_FAULT 1
`define ASCR_EV_BADSPAN 2
`define ASCR_EV_N 3

// ----------------------------------------
// span code limits
// ----------------------------------------
`define ASCR_SPAN_2V5 4'h0
`define ASCR_SPAN_5V 4'h1
`define ASCR_SPAN_RSVD_LO 4'hC

`endif

// File: hdl/ascr_pkg.sv
package ascr_pkg;

  typedef enum logic [1:0] {
    ASCR_PWR_NORMAL,
    ASCR_PWR_STANDBY,
    ASCR_PWR_AUTO_STANDBY,
    ASCR_PWR_SHUTDOWN
  } ascr_power_t;

  typedef enum logic [1:0] {
    ASCR_SPAN_PM2V5,
    ASCR_SPAN_PM5V,
    ASCR_SPAN_PM10V,
    ASCR_SPAN_RESERVED
  } ascr_span_t;

  typedef struct packed {
    logic status_header_en;
    logic external_averaging_clock_en;
    logic [2:0] serial_result_lane_count;
    ascr_power_t power_state;
  } ascr_cfg_t;

  typedef struct packed {
    ascr_span_t ch4_input_span;
    ascr_span_t ch3_input_span;
    ascr_span_t ch2_input_span;
    ascr_span_t ch1_input_span;
  } ascr_spans_t;

endpackage

// File: hdl/ascr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascr_defs.svh"

module ascr_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic partial_reset_in,
  input wire logic [7:0] logic_fault_register_in,
  output var ascr_pkg::ascr_cfg_t cfg_out,
  output var ascr_pkg::ascr_spans_t spans_out,
  output logic irq_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic boot_done;
    logic reset_seen;
    logic [7:0] setup;
    logic [7:0] span12;
    logic [7:0] span34;
    logic [`ASCR_EV_N-1:0] irq_stat;
    logic [`ASCR_EV_N-1:0] irq_mask;
    logic fault_q;
    logic [31:0] rdata;
  } ascr_regs_state_t;

  ascr_regs_state_t st_r;
  ascr_regs_state_t st_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  function automatic ascr_pkg::ascr_span_t span_decode(input logic [3:0] code);
    if (code == `ASCR_SPAN_2V5) begin
      span_decode = ascr_pkg::ASCR_SPAN_PM2V5;
    end else if (code == `ASCR_SPAN_5V) begin
      span_decode = ascr_pkg::ASCR_SPAN_PM5V;
    end else if (code >= `ASCR_SPAN_RSVD_LO) begin
      span_decode = ascr_pkg::ASCR_SPAN_RESERVED;
    end else begin
      span_decode = ascr_pkg::ASCR_SPAN_PM10V;
    end
  endfunction

  function automatic logic span_bad(input logic [7:0] pair);
    span_bad = (pair[7:4] >= `ASCR_SPAN_RSVD_LO) || (pair[3:0] >= `ASCR_SPAN_RSVD_LO);
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic setup_ph;
  logic access_ph;
  logic hit_status;
  logic hit_setup;
  logic hit_span12;
  logic hit_span34;
  logic hit_istat;
  logic hit_imask;
  logic hit_any;
  logic wr_ok;
  logic rd_done;
  logic fault_now;
  logic [7:0] status_val;
  logic [7:0] wbyte;

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign hit_status = paddr_in == byte_addr(`ASCR_IDX_STATUS);
  assign hit_setup = paddr_in == byte_addr(`ASCR_IDX_SETUP);
  assign hit_span12 = paddr_in == byte_addr(`ASCR_IDX_SPAN12);
  assign hit_span34 = paddr_in == byte_addr(`ASCR_IDX_SPAN34);
  assign hit_istat = paddr_in == byte_addr(`ASCR_IDX_IRQ_STAT);
  assign hit_imask = paddr_in == byte_addr(`ASCR_IDX_IRQ_MASK);
  assign hit_any = hit_status | hit_setup | hit_span12 | hit_span34 | hit_istat | hit_imask;
  // low byte lane only; a write without it changes nothing
  assign wr_ok = access_ph && pwrite_in && hit_any && pstrb_in[0];
  assign rd_done = access_ph && !pwrite_in && hit_status;
  assign wbyte = pwdata_in[7:0];
  // summary of the fault flags, live level
  assign fault_now = |logic_fault_register_in;

  always_comb begin
    status_val = `ASCR_RST_STATUS;
    status_val[`ASCR_ST_RESET_BIT] = st_r.reset_seen;
    status_val[`ASCR_ST_FAULT_BIT] = fault_now;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [`ASCR_EV_N-1:0] ev;
    ev = '0;
    st_nxt = st_r;
    st_nxt.boot_done = 1'b1;
    st_nxt.fault_q = fault_now;

    // register read data during setup so it leaves a flop
    if (setup_ph) begin
      st_nxt.rdata = '0;
      if (hit_status) begin
        st_nxt.rdata[7:0] = status_val;
      end else if (hit_setup) begin
        st_nxt.rdata[7:0] = st_r.setup & `ASCR_SETUP_WMASK;
      end else if (hit_span12) begin
        st_nxt.rdata[7:0] = st_r.span12;
      end else if (hit_span34) begin
        st_nxt.rdata[7:0] = st_r.span34;
      end else if (hit_istat) begin
        st_nxt.rdata[`ASCR_EV_N-1:0] = st_r.irq_stat;
      end else if (hit_imask) begin
        st_nxt.rdata[`ASCR_EV_N-1:0] = st_r.irq_mask;
      end
    end

    // a status read acknowledges the reset flag
    if (rd_done) begin
      st_nxt.reset_seen = 1'b0;
    end

    if (wr_ok) begin
      if (hit_setup) begin
        st_nxt.setup = wbyte & `ASCR_SETUP_WMASK;
      end
      if (hit_span12) begin
        st_nxt.span12 = wbyte;
        ev[`ASCR_EV_BADSPAN] = span_bad(wbyte);
      end
      if (hit_span34) begin
        st_nxt.span34 = wbyte;
        ev[`ASCR_EV_BADSPAN] = span_bad(wbyte);
      end
      if (hit_istat) begin
        st_nxt.irq_stat = st_r.irq_stat & ~wbyte[`ASCR_EV_N-1:0];
      end
      if (hit_imask) begin
        st_nxt.irq_mask = wbyte[`ASCR_EV_N-1:0];
      end
    end

    // partial reset puts the setup and spans back to defaults
    if (partial_reset_in) begin
      st_nxt.setup = `ASCR_RST_SETUP;
      st_nxt.span12 = `ASCR_RST_SPAN;
      st_nxt.span34 = `ASCR_RST_SPAN;
    end

    // set beats clear for every hardware flag
    if (partial_reset_in || !st_r.boot_done) begin
      st_nxt.reset_seen = 1'b1;
      ev[`ASCR_EV_RESET] = 1'b1;
    end
    ev[`ASCR_EV_FAULT] = fault_now && !st_r.fault_q;
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r.boot_done <= 1'b0;
      st_r.reset_seen <= 1'b0;
      st_r.setup <= `ASCR_RST_SETUP;
      st_r.span12 <= `ASCR_RST_SPAN;
      st_r.span34 <= `ASCR_RST_SPAN;
      st_r.irq_stat <= `ASCR_RST_IRQ;
      st_r.irq_mask <= `ASCR_RST_IRQ;
      st_r.fault_q <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // zero wait: read data was loaded in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = access_ph && !hit_any;
  assign prdata_out = st_r.rdata;
  assign irq_out = |(st_r.irq_stat & st_r.irq_mask);

  always_comb begin
    logic [1:0] lanes;
    lanes = st_r.setup[`ASCR_SU_LANES_HI:`ASCR_SU_LANES_LO];
    cfg_out.status_header_en = st_r.setup[`ASCR_SU_HEADER_BIT];
    cfg_out.external_averaging_clock_en = st_r.setup[`ASCR_SU_EXTCLK_BIT];
    case (lanes)
      2'h1: cfg_out.serial_result_lane_count = 3'h2;
      2'h2: cfg_out.serial_result_lane_count = 3'h4;
      default: cfg_out.serial_result_lane_count = 3'h1;
    endcase
    cfg_out.power_state = ascr_pkg::ascr_power_t'(
      st_r.setup[`ASCR_SU_POWER_HI:`ASCR_SU_POWER_LO]);
  end

  assign spans_out.ch1_input_span = span_decode(st_r.span12[3:0]);
  assign spans_out.ch2_input_span = span_decode(st_r.span12[7:4]);
  assign spans_out.ch3_input_span = span_decode(st_r.span34[3:0]);
  assign spans_out.ch4_input_span = span_decode(st_r.span34[7:4]);

endmodule // ascr_regs

`default_nettype wire

// File: sim/adc_status_config_range_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ascr_defs.svh"
module adc_status_config_range_regs_tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic prst = 1'b0;
  logic [7:0] flt = 8'h00;
  logic psel, pen, pwr, err, rdy, irq, err_q;
  logic [11:0] pa;
  logic [31:0] pwd, prd, q;
  ascr_pkg::ascr_cfg_t cfg;
  ascr_pkg::ascr_spans_t spn;
  int bad_count = 0;
  int compares = 0;
  localparam logic [11:0] A_ST = {2'b00, `ASCR_IDX_STATUS, 2'b00};
  localparam logic [11:0] A_SU = {2'b00, `ASCR_IDX_SETUP, 2'b00};
  localparam logic [11:0] A_S12 = {2'b00, `ASCR_IDX_SPAN12, 2'b00};
  localparam logic [11:0] A_S34 = {2'b00, `ASCR_IDX_SPAN34, 2'b00};
  localparam logic [11:0] A_IS = {2'b00, `ASCR_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_IM = {2'b00, `ASCR_IDX_IRQ_MASK, 2'b00};
  ascr_regs ascr_regs_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hF),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .partial_reset_in(prst),
    .logic_fault_register_in(flt), .cfg_out(cfg), .spans_out(spn), .irq_out(irq));
  ascr_host ascr_host_inst (.clk_in(clk_in), .prdata_in(prd), .pready_in(rdy),
    .pslverr_in(err), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
    .paddr_out(pa), .pwdata_out(pwd));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // the one-step delay lets the completing edge land before outputs are looked at
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ascr_host_inst.xfer(a, 1'b1, d, q, err_q);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic e;
    ascr_host_inst.xfer(a, 1'b0, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic irq_is(input logic x);
    repeat (2) @(posedge clk_in);
    #1 chk({31'h0, irq}, {31'h0, x});
  endtask
  function automatic logic [6:0] ecfg(input logic [7:0] d);
    logic [2:0] n;
    n = d[4:3] == 2'b01 ? 3'h2 : d[4:3] == 2'b10 ? 3'h4 : 3'h1;
    return {d[6:5], n, d[1:0]};
  endfunction
  function automatic logic [1:0] es(input logic [3:0] c);
    return c == 4'h0 ? 2'h0 : c == 4'h1 ? 2'h1 : c < 4'hC ? 2'h2 : 2'h3;
  endfunction
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #80000;
    bad_count++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    d = $urandom(32'he3eaf63d);
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(A_ST, 32'h80);
    rd(A_ST, 32'h00);
    rd(A_SU, 32'h08);
    rd(A_S12, 32'h33);
    rd(A_S34, 32'h33);
    $display("test reset done");
    for (int i = 0; i < 24; i++) begin
      d = i < 4 ? 32'hFFFFFF84 | (i << 3) | i : $urandom;
      wr(A_SU, d);
      chk(32'(cfg), 32'(ecfg(d[7:0])));
      rd(A_SU, d & 32'h7B);
    end
    $display("test setup done");
    for (int i = 0; i < 16; i++) begin
      d = ($urandom & 32'hFFFFFF00) | (i << 4) | (15 - i);
      wr(A_S12, d);
      wr(A_S34, ~d);
      chk(32'(spn), {24'h0, es(~d[7:4]), es(~d[3:0]), es(d[7:4]), es(d[3:0])});
      chk({31'h0, err_q}, 32'h0);
      rd(A_S12, d & 32'hFF);
      rd(A_S34, ~d & 32'hFF);
    end
    $display("test spans done");
    irq_is(1'b0);
    @(posedge clk_in);
    flt <= 8'h01 << ($urandom % 8);
    rd(A_ST, 32'h40);
    wr(A_IM, 32'h2);
    irq_is(1'b1);
    @(posedge clk_in);
    flt <= 8'h00;
    wr(A_IS, 32'h2);
    irq_is(1'b0);
    rd(A_ST, 32'h00);
    wr(A_IM, 32'h1);
    irq_is(1'b1);
    wr(A_IS, 32'h1);
    irq_is(1'b0);
    $display("test fault done");
    wr(A_SU, 32'h71);
    @(posedge clk_in);
    prst <= 1'b1;
    @(posedge clk_in);
    prst <= 1'b0;
    rd(A_ST, 32'h80);
    rd(A_SU, 32'h08);
    rd(A_S12, 32'h33);
    wr(12'h014, 32'hFF);
    // error answer stands only in the access cycle, so take the captured copy
    chk({31'h0, err_q}, 32'h1);
    rd(12'h014, 32'h0);
    rd(A_S34, 32'h33);
    $display("test partial reset done");
    close_out();
  end
endmodule // adc_status_config_range_regs_tb_top
`default_nettype wire

// File: sim/ascr_host.sv
`timescale 1ns/1ps
`default_nettype none
module ascr_host (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  initial begin
    {psel_out, penable_out, pwrite_out} = 3'h0;
    paddr_out = 12'h000;
    pwdata_out = 32'h0;
  end
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    {psel_out, penable_out, pwrite_out} <= {2'b10, w};
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    e = pslverr_in;
    {psel_out, penable_out} <= 2'b00;
    // released lines flip so stale values cannot pass
    paddr_out <= ~a;
    pwdata_out <= ~d;
  endtask
endmodule // ascr_host
`default_nettype wire

// File: sim/ascr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ascr_regs_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic partial_reset_in,
  input wire ascr_pkg::ascr_cfg_t cfg_out,
  input wire ascr_pkg::ascr_spans_t spans_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic acc, wr, rd, map;
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in && pstrb_in[0] && !partial_reset_in;
  assign rd = acc && !pwrite_in;
  assign map = paddr_in inside {12'h004, 12'h008, 12'h00C, 12'h010, 12'h020, 12'h024};
  function automatic logic [1:0] sp(input logic [3:0] c);
    return c == 4'h0 ? 2'h0 : c == 4'h1 ? 2'h1 : c < 4'hC ? 2'h2 : 2'h3;
  endfunction
  property p_rst; $rose(rst_n_in) |-> cfg_out == 7'h08 && spans_out == 8'hAA; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_cfg;
    wr && paddr_in == 12'h008 |=> {cfg_out[6:5], cfg_out[1:0]} ==
      $past({pwdata_in[6:5], pwdata_in[1:0]});
  endproperty
  a_cfg: assert property (p_cfg) else $error("setup fields wrong");
  property p_lanes;
    wr && paddr_in == 12'h008 ##1 $past(pwdata_in[4:3]) == 2'b10 |-> cfg_out[4:2] == 3'h4;
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane count wrong");
  property p_s12;
    wr && paddr_in == 12'h00C |=> spans_out[3:0] ==
      {sp($past(pwdata_in[7:4])), sp($past(pwdata_in[3:0]))};
  endproperty
  a_s12: assert property (p_s12) else $error("span 1 2 wrong");
  property p_s34;
    wr && paddr_in == 12'h010 |=> spans_out[7:4] ==
      {sp($past(pwdata_in[7:4])), sp($past(pwdata_in[3:0]))};
  endproperty
  a_s34: assert property (p_s34) else $error("span 3 4 wrong");
  property p_rsv; rd && paddr_in == 12'h008 |-> (prdata_out & 32'hFFFFFF84) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("setup reserved bits set");
  property p_st; rd && paddr_in == 12'h004 |-> (prdata_out & 32'hFFFFFF3F) == 32'h0; endproperty
  a_st: assert property (p_st) else $error("status reserved bits set");
  property p_prst; partial_reset_in |=> cfg_out == 7'h08 && spans_out == 8'hAA; endproperty
  a_prst: assert property (p_prst) else $error("partial reset missed");
  property p_err; acc && !map |-> pslverr_out && (pwrite_in || prdata_out == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  c_wr: cover property (wr && paddr_in == 12'h008);
  c_err: cover property (acc && !map);
  c_prst: cover property (partial_reset_in);
endmodule // ascr_regs_monitor
bind ascr_regs ascr_regs_monitor ascr_regs_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pslverr_out(pslverr_out), .partial_reset_in(partial_reset_in), .cfg_out(cfg_out),
  .spans_out(spans_out));
`default_nettype wire
